// file: design/sbs_map.vh
// Constants of the synchronous burst memory: sizes, fields, resets
`ifndef SBS_MAP_VH
`define SBS_MAP_VH

// Array geometry
`define SBS_ADDR_W      15
`define SBS_DATA_W      18
`define SBS_WORDS       32768

// Byte lanes of the data word
`define SBS_LANES       2
`define SBS_LANE_W      9
`define SBS_LO_LSB      0
`define SBS_LO_MSB      8
`define SBS_HI_LSB      9
`define SBS_HI_MSB      17

// Burst counter field of the word address
`define SBS_BURST_LSB   0
`define SBS_BURST_MSB   1
`define SBS_BASE_LSB    2
`define SBS_BASE_MSB    14

// Write posting buffer
`define SBS_FIFO_DEPTH  16
`define SBS_FIFO_AW     4

// Reset values
`define SBS_CNT_RST     2'h0
`define SBS_BASE_RST    15'h0000
`define SBS_DOUT_RST    18'h00000

`endif

// file: design/sbs_fifo.v
// Parameterised first-word-fall-through FIFO with valid/ready on both sides
`default_nettype none

module sbs_fifo #(
    parameter W  = 35,
    parameter D  = 16,
    parameter AW = 4
) (
    // Clock, reset, enable
    input  wire           clk,
    input  wire           rstn,
    input  wire           ce,
    // Fill side
    input  wire           in_valid,
    output wire           in_ready,
    input  wire [W-1:0]   in_data,
    // Drain side
    output wire           out_valid,
    input  wire           out_ready,
    output wire [W-1:0]   out_data
);

    reg  [W-1:0]  mem_q [0:D-1];
    reg  [AW-1:0] wp_q;
    reg  [AW-1:0] rp_q;
    reg  [AW:0]   cnt_q;
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rp_q];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule // sbs_fifo

`default_nettype wire

// file: design/sbs_sram.v
// Synchronous burst static memory, 32K words of 18 bits, self-timed write
`include "sbs_map.vh"
`default_nettype none

module sbs_sram #(
    parameter ADDR_W     = `SBS_ADDR_W,
    parameter DATA_W     = `SBS_DATA_W,
    parameter WORDS      = `SBS_WORDS,
    parameter FIFO_DEPTH = `SBS_FIFO_DEPTH,
    parameter FIFO_AW    = `SBS_FIFO_AW
) (
    // Clock, reset, enable
    input  wire              core_clk,
    input  wire              rstn,
    input  wire              clk_en,
    // Address and burst control
    input  wire [ADDR_W-1:0] word_addr_pins,
    input  wire              processor_addr_strobe_n,
    input  wire              controller_addr_strobe_n,
    input  wire              burst_step_n,
    input  wire              chip_select_n,
    // Byte write enables
    input  wire              low_byte_write_n,
    input  wire              high_byte_write_n,
    // Asynchronous output enable
    input  wire              output_enable_n,
    // Shared data pins
    input  wire [DATA_W-1:0] shared_data_pins_i,
    output reg  [DATA_W-1:0] shared_data_pins_o,
    output wire              shared_data_pins_oe
);

    // Burst states, one-hot
    localparam [1:0] ST_DESEL = 2'h1;
    localparam [1:0] ST_BURST = 2'h2;

    localparam FW = ADDR_W + `SBS_LANES + DATA_W;

    // Storage array, no reset
    reg  [DATA_W-1:0] mem_q [0:WORDS-1];

    reg  [1:0]        st_q;
    reg  [1:0]        st_d;
    reg  [ADDR_W-1:0] base_q;
    reg  [ADDR_W-1:0] base_d;
    reg  [1:0]        cnt_q;
    reg  [1:0]        cnt_d;
    reg               rd_q;
    reg               rd_d;
    reg  [ADDR_W-1:0] acc_addr;
    integer           l;
    reg               is_wr;
    reg               is_rd;

    wire              any_we;
    wire [1:0]        lane_we;
    wire [1:0]        cnt_nx;
    wire              fifo_in_ready;
    wire              fifo_out_valid;
    wire [FW-1:0]     fifo_out_data;
    wire [FW-1:0]     fifo_in_data;
    wire              push_wr;
    wire [ADDR_W-1:0] head_addr;
    wire [1:0]        head_we;
    wire [DATA_W-1:0] head_data;
    wire [DATA_W-1:0] rd_word;
    wire [DATA_W-1:0] rd_merged;

    assign lane_we = {~high_byte_write_n, ~low_byte_write_n};
    assign any_we  = |lane_we;
    assign cnt_nx  = cnt_q + 2'h1;

    // Cycle decode, all on pin levels taken at the rising edge
    always @* begin
        is_wr     = 1'b0;
        is_rd     = 1'b0;
        st_d      = st_q;
        base_d    = base_q;
        cnt_d     = cnt_q;
        acc_addr  = {base_q[`SBS_BASE_MSB:`SBS_BASE_LSB],
                     base_q[`SBS_BURST_MSB:`SBS_BURST_LSB] ^ cnt_q};
        if (!processor_addr_strobe_n || !controller_addr_strobe_n) begin
            if (chip_select_n) begin
                st_d     = ST_DESEL;
            end else begin
                st_d     = ST_BURST;
                base_d   = word_addr_pins;
                cnt_d    = `SBS_CNT_RST;
                acc_addr = word_addr_pins;
                if (!processor_addr_strobe_n) begin
                    is_rd = 1'b1;
                end else begin
                    is_wr = any_we;
                    is_rd = ~any_we;
                end
            end
        end else begin
            case (st_q)
                ST_BURST: begin
                    if (!burst_step_n) begin
                        cnt_d    = cnt_nx;
                        acc_addr = {base_q[`SBS_BASE_MSB:`SBS_BASE_LSB],
                                    base_q[`SBS_BURST_MSB:`SBS_BURST_LSB]
                                    ^ cnt_nx};
                    end
                    is_wr = any_we;
                    is_rd = ~any_we;
                end
                ST_DESEL: begin
                    st_d = ST_DESEL;
                end
                default: begin
                    st_d = ST_DESEL;
                end
            endcase
        end
        rd_d = is_rd;
    end

    // Burst state and read-cycle flag
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q   <= ST_DESEL;
            base_q <= `SBS_BASE_RST;
            cnt_q  <= `SBS_CNT_RST;
            rd_q   <= 1'b0;
        end else if (clk_en) begin
            st_q   <= st_d;
            base_q <= base_d;
            cnt_q  <= cnt_d;
            rd_q   <= rd_d;
        end
    end

    // Write posting: address, lane enables and data captured at the edge
    assign fifo_in_data = {acc_addr, lane_we, shared_data_pins_i};
    assign push_wr      = is_wr & fifo_in_ready;

    sbs_fifo #(
        .W  (FW),
        .D  (FIFO_DEPTH),
        .AW (FIFO_AW)
    ) u_wr_fifo (
        .clk       (core_clk),
        .rstn      (rstn),
        .ce        (clk_en),
        .in_valid  (push_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    assign head_addr = fifo_out_data[FW-1:`SBS_LANES+DATA_W];
    assign head_we   = fifo_out_data[`SBS_LANES+DATA_W-1:DATA_W];
    assign head_data = fifo_out_data[DATA_W-1:0];
    assign rd_word   = mem_q[acc_addr];

    // Self-timed array write of the posted word; one process, one writer
    always @(posedge core_clk) begin
        if (clk_en && fifo_out_valid) begin
            for (l = 0; l < `SBS_LANES; l = l + 1) begin
                if (head_we[l]) begin
                    mem_q[head_addr][l*`SBS_LANE_W +: `SBS_LANE_W] <=
                        head_data[l*`SBS_LANE_W +: `SBS_LANE_W];
                end
            end
        end
    end

    // Per lane: forwarding of the posted word
    genvar g;
    generate
        for (g = 0; g < `SBS_LANES; g = g + 1) begin : g_lane
            assign rd_merged[g*`SBS_LANE_W +: `SBS_LANE_W] =
                (fifo_out_valid && head_we[g] && head_addr == acc_addr) ?
                head_data[g*`SBS_LANE_W +: `SBS_LANE_W] :
                rd_word[g*`SBS_LANE_W +: `SBS_LANE_W];
        end
    endgenerate

    // Read data registered at the access edge, no extra stage
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shared_data_pins_o <= `SBS_DOUT_RST;
        end else if (clk_en && is_rd) begin
            shared_data_pins_o <= rd_merged;
        end
    end

    // Drive only in read cycles with enable low, without the clock
    assign shared_data_pins_oe = rd_q & ~output_enable_n;

endmodule // sbs_sram

`default_nettype wire

// file: test/sbs_monitor.sv
// Port checker of the burst memory
`default_nettype none
module sbs_monitor (
    // Clock, reset, enable
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        clk_en,
    // Address and control
    input wire logic [14:0] word_addr_pins,
    input wire logic        processor_addr_strobe_n,
    input wire logic        controller_addr_strobe_n,
    input wire logic        chip_select_n,
    input wire logic        low_byte_write_n,
    input wire logic        high_byte_write_n,
    input wire logic        output_enable_n,
    // Data pins
    input wire logic [17:0] shared_data_pins_i,
    input wire logic [17:0] shared_data_pins_o,
    input wire logic        shared_data_pins_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic ps = processor_addr_strobe_n;
    wire logic cs = ~chip_select_n;
    wire logic rd = low_byte_write_n & high_byte_write_n;
    wire logic ld = clk_en & ~(ps & controller_addr_strobe_n);
    wire logic pr = ld & ~ps & cs;
    wire logic cw = ld & ps & cs & ~low_byte_write_n & ~high_byte_write_n;
    wire logic go = clk_en & ps & controller_addr_strobe_n & rd & ~cs;
    wire logic oe = shared_data_pins_oe;
    wire logic g = output_enable_n;
    wire logic [17:0] q = shared_data_pins_o;
    logic rd_m_q;
    logic sel_m_q;
    // Reference: last taken cycle was a selected read
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_m_q  <= 1'b0;
            sel_m_q <= 1'b0;
        end else if (clk_en) begin
            if (!ps || !controller_addr_strobe_n) begin
                sel_m_q <= cs;
                rd_m_q  <= cs && (!ps || rd);
            end else begin
                rd_m_q  <= sel_m_q && rd;
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    oe_needs_en_a: assert property (oe |-> !g && rd_m_q)
        else $error("pins driven with enable off");
    oe_on_read_a: assert property (rd_m_q && !g |-> oe)
        else $error("read data not driven");
    proc_read_a: assert property (pr |=> oe || g)
        else $error("no read after processor load");
    ctrl_write_a: assert property (cw |=> !oe && $stable(q))
        else $error("write cycle drove pins");
    desel_float_a: assert property (ld && !cs |=> !oe)
        else $error("deselect did not float pins");
    cont_read_a: assert property (pr ##1 go |=> oe || g)
        else $error("burst read lost");
    forward_a: assert property (cw ##1 (pr && $stable(word_addr_pins))
        |=> q == $past(shared_data_pins_i, 2))
        else $error("read after write wrong");
    freeze_hold_a: assert property (!clk_en |=> $stable(q))
        else $error("data changed while frozen");
    pwr_up_a: assert property ($rose(rstn) |-> !oe)
        else $error("pins driven after reset");
endmodule // sbs_monitor
bind sbs_sram sbs_monitor u_mon (.*);
`default_nettype wire

// file: test/sbs_master.sv
// Bus master model: drives write data, yields to the memory
`default_nettype none
module sbs_master (
    // Clock and memory side
    input  wire logic        core_clk,
    input  wire logic        dev_oe,
    input  wire logic [17:0] dev_q,
    // Master side
    input  wire logic        drv,
    input  wire logic [17:0] wdat,
    output var  logic [17:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [17:0] last_q = 18'h00000;
    // Released bus toggles so stale data never matches
    always_comb begin
        if (dev_oe) bus = dev_q;
        else if (drv) bus = wdat;
        else bus = ~last_q;
    end
    always @(posedge core_clk) last_q <= bus;
endmodule // sbs_master
`default_nettype wire

// file: test/sync_burst_sram_32kx18_tb.sv
// Self-checking bench of the burst memory
`default_nettype none
module sync_burst_sram_32kx18_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  c8 = 8'h7F;
    logic [14:0] a = 15'h0000;
    logic [14:0] ra = 15'h0000;
    logic [17:0] d = 18'h00000;
    logic        drv = 1'b0;
    wire  [17:0] bus;
    wire  [17:0] q;
    wire         oe;
    logic [17:0] rm [0:32767];
    logic [14:0] base = 15'h0000;
    logic [1:0]  k = 2'h0;
    logic        sel = 1'b0;
    logic        rdq = 1'b0;
    logic [17:0] ex = 18'h00000;
    integer      errors = 0;
    integer      compares = 0;
    integer      seed = 32'hac1a;
    integer      i;
    integer      j;
    // Codes {ce, proc, ctrl, step, cs, lw, hw, oe}, all but ce active low
    logic [7:0]  seq [0:20] = '{8'hD1, 8'hE9, 8'hE9, 8'hE9, 8'hEE, 8'hB0,
        8'hEE, 8'hEE, 8'hEE, 8'hEE, 8'hFE, 8'hF3, 8'hF5, 8'hD6, 8'hB7,
        8'hD1, 8'hB6, 8'hDE, 8'hEE, 8'h36, 8'hBE};
    sbs_sram u_dut (
        .core_clk(core_clk), .rstn(rstn), .clk_en(c8[7]),
        .word_addr_pins(a), .processor_addr_strobe_n(c8[6]),
        .controller_addr_strobe_n(c8[5]), .burst_step_n(c8[4]),
        .chip_select_n(c8[3]), .low_byte_write_n(c8[2]),
        .high_byte_write_n(c8[1]), .output_enable_n(c8[0]),
        .shared_data_pins_i(bus), .shared_data_pins_o(q),
        .shared_data_pins_oe(oe)
    );
    sbs_master u_mst (.core_clk(core_clk), .dev_oe(oe), .dev_q(q),
        .drv(drv), .wdat(d), .bus(bus));
    function automatic logic [14:0] ea();
        return {base[14:2], base[1:0] ^ k};
    endfunction
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic op(input logic [7:0] cv);
        logic wr;
        wr = 1'b0;
        c8 = cv;
        a = ra;
        d = 18'($random(seed));
        drv = cv[6] && !(cv[2] && cv[1]);
        @(posedge core_clk);
        #1;
        if (cv[7]) begin
            if (!cv[6] || !cv[5]) begin
                sel = !cv[3];
                base = ra;
                k = 2'h0;
                wr = cv[6] && !(cv[2] && cv[1]);
            end else begin
                k = k + {1'b0, !cv[4]};
                wr = !(cv[2] && cv[1]);
            end
            wr = wr && sel;
            if (wr && !cv[2]) rm[ea()][8:0] = d[8:0];
            if (wr && !cv[1]) rm[ea()][17:9] = d[17:9];
            rdq = sel && !wr;
            if (rdq) ex = rm[ea()];
        end
        check({17'h0, oe}, {17'h0, rdq && !cv[0]});
        if (rdq && !$isunknown(ex)) check(q, ex);
    endtask
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        check({17'h0, oe}, 18'h00000);
        for (i = 0; i < 8; i = i + 1) begin
            ra = (i == 0) ? 15'h7FFF : 15'($random(seed));
            for (j = 0; j < 21; j = j + 1) op(seq[j]);
        end
        report_and_stop();
    end
endmodule // sync_burst_sram_32kx18_tb
`default_nettype wire
